// [hw/iorel_pkg.sv]
`default_nettype none
package iorel_pkg;
    // ****************************************
    // addresses and sizes
    // ****************************************
    localparam logic [31:0] ADDR_PIN_ASSERT = 32'hfec00020;
    localparam logic [31:0] ADDR_EOI_CLEAR  = 32'hfec00040;
    localparam int          NUM_PINS_DEF    = 24;
    localparam int          IDX_W           = 5;
    localparam logic [4:0]  IRQ_NUM_MAX     = 5'h17;
    localparam logic [4:0]  IDX_ZERO        = 5'h00;
    // ****************************************
    // delivery mode codes
    // ****************************************
    localparam logic [2:0] DLV_FIXED  = 3'h0;
    localparam logic [2:0] DLV_LOWPRI = 3'h1;
    localparam logic [2:0] DLV_SMI    = 3'h2;
    localparam logic [2:0] DLV_RSVD   = 3'h3;
    localparam logic [2:0] DLV_NMI    = 3'h4;
    localparam logic [2:0] DLV_INIT   = 3'h5;
    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic [7:0]  dest;
        logic [38:0] rsvd;
        logic        mask;
        logic        trig;
        logic        remote;
        logic        pol;
        logic        status;
        logic        dmode;
        logic [2:0]  deliv;
        logic [7:0]  vector;
    } iorel_entry_t;
    typedef struct packed {
        logic [7:0]       dest;
        logic             dmode;
        logic [2:0]       deliv;
        logic             trig;
        logic [7:0]       vector;
        logic [IDX_W-1:0] idx;
    } iorel_msg_t;
    localparam iorel_entry_t ENTRY_RESET = 64'h0000_0000_0001_0000;
    typedef enum logic [1:0] {
        ST_SCAN = 2'b01,
        ST_SEND = 2'b10
    } iorel_state_t;
endpackage
`default_nettype wire

// [hw/iorel_top.sv]
`timescale 1ns/1ps
`default_nettype none
module iorel_top
    import iorel_pkg::*;
#(
    parameter int NUM_PINS = NUM_PINS_DEF
) (
    input  wire logic                SYS_CLK,
    input  wire logic                RST,
    input  wire logic [NUM_PINS-1:0] IRQ_PIN,
    input  wire logic                MEM_WE,
    input  wire logic [31:0]         MEM_ADDR,
    input  wire logic [31:0]         MEM_WDATA,
    input  wire logic                ENT_WE,
    input  wire logic [IDX_W-1:0]    ENT_IDX,
    input  wire logic [63:0]         ENT_WDATA,
    output logic      [63:0]         ENT_RDATA,
    output logic                     MSG_VALID,
    input  wire logic                MSG_READY,
    output iorel_msg_t               MSG
);
    // ****************************************
    // pin synchroniser and decode
    // ****************************************
    logic [NUM_PINS-1:0]  pin_s1_q;
    logic [NUM_PINS-1:0]  pin_s2_q;
    logic [NUM_PINS-1:0]  act_prev_q;
    logic [NUM_PINS-1:0]  active;
    logic [NUM_PINS-1:0]  pend_q;
    logic [NUM_PINS-1:0]  remote_q;
    logic [NUM_PINS-1:0]  req;
    logic [NUM_PINS-1:0]  eoi_match;
    logic [NUM_PINS-1:0]  pa_hit;
    iorel_entry_t         cfg_q [NUM_PINS];
    iorel_state_t         st_q;
    logic [IDX_W-1:0]     idx_q;
    logic [IDX_W-1:0]     cur_q;
    logic [IDX_W-1:0]     idx_next;
    iorel_msg_t           msg_q;
    logic [63:0]          rdata_q;

    // two flops: pins are asynchronous to the system clock
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            pin_s1_q   <= '0;
            pin_s2_q   <= '0;
            act_prev_q <= '0;
        end else begin
            pin_s1_q   <= IRQ_PIN;
            pin_s2_q   <= pin_s1_q;
            act_prev_q <= active;
        end
    end

    // both write registers are write-only; only the low bits matter
    // write decode
    wire        wr_pa   = MEM_WE && (MEM_ADDR == ADDR_PIN_ASSERT);
    wire        wr_eoi  = MEM_WE && (MEM_ADDR == ADDR_EOI_CLEAR);
    wire [4:0]  pa_num  = MEM_WDATA[4:0];
    wire        pa_ok   = wr_pa && (pa_num <= IRQ_NUM_MAX);
    wire [7:0]  eoi_vec = MEM_WDATA[7:0];
    wire        hs      = MSG_VALID && MSG_READY;
    wire        in_scan = (st_q == ST_SCAN);
    wire        launch  = in_scan && req[idx_q];
    wire        cur_rsv = cfg_q[idx_q].deliv == DLV_RSVD;
    wire        wrap    = (idx_q == IDX_W'(NUM_PINS - 1));

    assign idx_next = wrap ? IDX_ZERO : idx_q + 5'h01;

    // ****************************************
    // per-pin sensing and flags
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_pin
            wire is_nmi  = cfg_q[g].deliv == DLV_NMI;
            wire msk     = cfg_q[g].mask;
            wire is_cur  = (cur_q == IDX_W'(g));
            wire is_idx  = (idx_q == IDX_W'(g));
            wire rise    = active[g] && !act_prev_q[g];
            wire done    = (hs && is_cur) || (launch && cur_rsv && is_idx);
            wire lvl_set = hs && is_cur && cfg_q[g].trig && !is_nmi;
            // polarity bit flips the pin sense
            assign active[g] = pin_s2_q[g] ^ cfg_q[g].pol;
            assign pa_hit[g] = pa_ok && (pa_num == IDX_W'(g));
            assign eoi_match[g] = wr_eoi && (cfg_q[g].vector == eoi_vec);
            assign req[g] = !msk && (is_nmi ? (pend_q[g] ||
                            (cfg_q[g].trig && active[g])) :
                            cfg_q[g].trig ?
                            ((active[g] || pend_q[g]) && !remote_q[g]) :
                            pend_q[g]);
            always_ff @(posedge SYS_CLK or posedge RST) begin
                if (RST) begin
                    pend_q[g]   <= 1'b0;
                    remote_q[g] <= 1'b0;
                end else begin
                    // an edge in the accept cycle re-arms, never lost
                    // mask drops pending
                    pend_q[g]   <= !msk && (rise || pa_hit[g] ||
                                   (pend_q[g] && !done));
                    remote_q[g] <= lvl_set ||
                                   (remote_q[g] && !eoi_match[g]);
                end
            end
        end
    endgenerate

    // ****************************************
    // entry table
    // ****************************************
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < NUM_PINS; i++) begin
                cfg_q[i] <= ENTRY_RESET;
            end
        end else if (ENT_WE && (ENT_IDX < IDX_W'(NUM_PINS))) begin
            cfg_q[ENT_IDX] <= ENT_WDATA;
        end
    end

    // status is pending or in flight
    // a level entry waiting for the scan counts as pending too
    wire [NUM_PINS-1:0] status;
    assign status = pend_q | req |
                    (NUM_PINS'(!in_scan) << cur_q);

    iorel_entry_t rd_ent;
    always_comb begin
        rd_ent        = ENTRY_RESET;
        rd_ent.mask   = 1'b0;
        if (ENT_IDX < IDX_W'(NUM_PINS)) begin
            rd_ent        = cfg_q[ENT_IDX];
            rd_ent.remote = remote_q[ENT_IDX];
            rd_ent.status = status[ENT_IDX];
        end
        rd_ent.rsvd = '0;
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rd_ent;
        end
    end
    assign ENT_RDATA = rdata_q;

    // ****************************************
    // scan loop and message build
    // ****************************************
    iorel_entry_t sel;
    iorel_msg_t   msg_d;
    assign sel = cfg_q[idx_q];
    // physical uses only low id bits
    wire [7:0] dest_d = sel.dmode ? sel.dest : {4'h0, sel.dest[3:0]};
    // smi, nmi and init carry no vector
    wire no_vec = (sel.deliv == DLV_SMI) || (sel.deliv == DLV_NMI) ||
                  (sel.deliv == DLV_INIT);
    always_comb begin
        msg_d        = '0;
        msg_d.dest   = dest_d;
        msg_d.dmode  = sel.dmode;
        // mode carried to the bus unit
        msg_d.deliv  = sel.deliv;
        msg_d.trig   = sel.trig && (sel.deliv != DLV_NMI);
        msg_d.vector = no_vec ? 8'h00 : sel.vector;
        msg_d.idx    = idx_q;
    end

    // a level nmi is resent every pass; scan order gives fairness
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            st_q  <= ST_SCAN;
            idx_q <= IDX_ZERO;
            cur_q <= IDX_ZERO;
            msg_q <= '0;
        end else begin
            case (st_q)
                ST_SCAN: begin
                    if (launch && !cur_rsv) begin
                        st_q  <= ST_SEND;
                        cur_q <= idx_q;
                        msg_q <= msg_d;
                    end else begin
                        idx_q <= idx_next;
                    end
                end
                ST_SEND: begin
                    if (MSG_READY) begin
                        st_q  <= ST_SCAN;
                        idx_q <= idx_next;
                    end
                end
                default: begin
                    st_q <= ST_SCAN;
                end
            endcase
        end
    end
    assign MSG_VALID = (st_q == ST_SEND);
    assign MSG       = msg_q;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    logic [NUM_PINS-1:0] match_prev_q;
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            match_prev_q <= '0;
        end else begin
            match_prev_q <= eoi_match;
        end
    end

    a_status_inflight: assert property (MSG_VALID |-> status[cur_q])
        else $error("status not pending while message waits");
    a_phys_dest: assert property (
        (MSG_VALID && !MSG.dmode) |-> (MSG.dest[7:4] == 4'h0))
        else $error("physical target has high id bits");
    a_fixed_vec: assert property (
        (MSG_VALID && MSG.deliv == DLV_FIXED) |->
        (MSG.vector == cfg_q[cur_q].vector) || $past(ENT_WE))
        else $error("fixed message vector wrong");
    a_lowpri_mode: assert property (
        (launch && sel.deliv == DLV_LOWPRI) |=> MSG.deliv == DLV_LOWPRI)
        else $error("lowest priority mode lost");
    a_smi_novec: assert property (
        (MSG_VALID && MSG.deliv == DLV_SMI) |-> MSG.vector == 8'h00)
        else $error("smi carries a vector");
    a_nmi_noflag: assert property (
        (hs && MSG.deliv == DLV_NMI && !remote_q[cur_q]) |=>
        !remote_q[$past(cur_q)])
        else $error("nmi set remote flag");
    a_nmi_edge: assert property (
        (MSG_VALID && MSG.deliv == DLV_NMI) |->
        (!MSG.trig && MSG.vector == 8'h00))
        else $error("nmi sent with level or vector");
    a_init_mode: assert property (
        (launch && sel.deliv == DLV_INIT) |=>
        (MSG_VALID && MSG.deliv == DLV_INIT))
        else $error("init not sent");
    a_pin_range: assert property (
        (MEM_WE && MEM_WDATA[4:0] > IRQ_NUM_MAX) |-> (pa_hit == '0))
        else $error("out of range pin write accepted");
    a_eoi_clear: assert property (
        (wr_eoi && !hs) |=> ((remote_q & match_prev_q) == '0))
        else $error("matching remote flag survived eoi");
    a_level_reissue: assert property (
        (in_scan && sel.trig && !sel.mask && active[idx_q] &&
         !remote_q[idx_q] && sel.deliv != DLV_RSVD) |=>
        (MSG_VALID && MSG.idx == $past(idx_q)))
        else $error("active level entry not reissued");
    a_mask_block: assert property (launch |-> !sel.mask)
        else $error("masked entry launched");
    a_level_flag: assert property (
        (hs && MSG.trig) |=> remote_q[$past(cur_q)])
        else $error("level accept did not set remote");
    a_rsvd_drop: assert property (
        (launch && cur_rsv) |=> !MSG_VALID)
        else $error("reserved mode sent");

    c_fixed_send: cover property (hs && MSG.deliv == DLV_FIXED);
    c_eoi_clear:  cover property (wr_eoi && (remote_q & eoi_match) != '0);
    c_pin_write:  cover property (pa_ok ##[1:60] hs);
    c_stall:      cover property (MSG_VALID && !MSG_READY [*3]);
    c_reissue:    cover property (eoi_match != '0 ##[1:40] hs);
endmodule
`default_nettype wire

// [sim/iorel_bus_model.sv]
`timescale 1ns/1ps
`default_nettype none
module iorel_bus_model
    import iorel_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       valid,
    input  wire iorel_msg_t msg,
    input  wire logic [3:0] stall,
    output logic            ready,
    output logic [7:0]      n_got,
    output iorel_msg_t      last_msg
);
    logic [3:0] wait_q;
    // ****************************************
    // acceptance of messages
    // ****************************************
    // slow accept keeps delivery pending
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ready <= 1'b0;
            wait_q <= 4'h0;
            n_got <= 8'h00;
            last_msg <= '0;
        end else if (valid && ready) begin
            ready <= 1'b0;
            wait_q <= 4'h0;
            n_got <= n_got + 8'h01;
            last_msg <= msg;
        end else if (valid && wait_q >= stall) begin
            ready <= 1'b1;
        end else if (valid) begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule
`default_nettype wire

// [sim/test_ioapic_redirect_eoi_logic.sv]
`timescale 1ns/1ps
`default_nettype none
module test_ioapic_redirect_eoi_logic;
    import iorel_pkg::*;
    typedef struct packed {
        logic [4:0] idx;
        logic [7:0] dest;
        logic       dm;
        logic [2:0] dlv;
        logic [7:0] vec;
        logic       sent;
        logic [7:0] xdest;
        logic [7:0] xvec;
    } iorel_row_t;
    logic clk, rst, mwe, ewe, ready, valid;
    logic [23:0] pins;
    logic [31:0] madr, mdat;
    logic [4:0] eidx;
    logic [63:0] ewd, erd;
    logic [3:0] stall;
    logic [7:0] n_got, n0;
    iorel_msg_t msg, last_msg, exp;
    iorel_row_t rows [6];
    int n_fail, checks_done;
    logic ok;
    iorel_top #(.NUM_PINS(24)) DUT (.SYS_CLK(clk), .RST(rst), .IRQ_PIN(pins),
        .MEM_WE(mwe), .MEM_ADDR(madr), .MEM_WDATA(mdat), .ENT_WE(ewe),
        .ENT_IDX(eidx), .ENT_WDATA(ewd), .ENT_RDATA(erd), .MSG_VALID(valid),
        .MSG_READY(ready), .MSG(msg));
    iorel_bus_model bus (.clk(clk), .rst(rst), .valid(valid), .msg(msg),
        .stall(stall), .ready(ready), .n_got(n_got), .last_msg(last_msg));
    // ****************************************
    // helpers
    // ****************************************
    task automatic tick(int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(string what, logic [63:0] e, logic [63:0] g);
        checks_done++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", what, e, g);
            n_fail++;
        end
    endtask
    function automatic logic [63:0] ent(logic [7:0] d, logic m, logic t,
        logic dm, logic [2:0] dl, logic [7:0] v);
        return {d, 39'h0, m, t, 3'b000, dm, dl, v};
    endfunction
    task automatic wr_ent(logic [4:0] i, logic [63:0] d);
        eidx = i;
        ewd = d;
        ewe = 1'b1;
        tick();
        ewe = 1'b0;
        // one idle edge so a following write never re-raises in one step
        tick();
    endtask
    task automatic mem_wr(logic [31:0] a, logic [31:0] d);
        madr = a;
        mdat = d;
        mwe = 1'b1;
        tick();
        mwe = 1'b0;
        tick();
    endtask
    task automatic rd_ent(logic [4:0] i);
        eidx = i;
        tick();
    endtask
    // waits up to one scan pass and a stall for n_got to move on
    task automatic wait_msg(int n);
        n0 = n_got;
        ok = 1'b0;
        for (int c = 0; c < 60 && !ok; c++) begin
            tick();
            ok = ((n_got - n0) >= n[7:0]);
        end
    endtask
    task automatic summarize();
        $display("checks_done %0d n_fail %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #400000;
        n_fail++;
        summarize();
    end
    // ****************************************
    // tests
    // ****************************************
    initial begin
        {mwe, ewe, pins, madr, mdat, eidx, ewd, stall} = '0;
        n_fail = 0;
        checks_done = 0;
        // vectors kept within 10h..feh where used
        rows = '{'{5'h03, 8'hab, 1'b0, DLV_FIXED, 8'h31, 1'b1, 8'h0b, 8'h31},
                 '{5'h17, 8'hc5, 1'b1, DLV_LOWPRI, 8'hfe, 1'b1, 8'hc5, 8'hfe},
                 '{5'h00, 8'h02, 1'b0, DLV_SMI, 8'h00, 1'b1, 8'h02, 8'h00},
                 '{5'h0a, 8'h0f, 1'b1, DLV_NMI, 8'h10, 1'b1, 8'h0f, 8'h00},
                 '{5'h11, 8'h31, 1'b0, DLV_INIT, 8'h20, 1'b1, 8'h01, 8'h00},
                 '{5'h05, 8'h01, 1'b0, DLV_RSVD, 8'h40, 1'b0, 8'h00, 8'h00}};
        rst = 1'b1;
        tick(4);
        rst = 1'b0;
        rd_ent(5'h04);
        chk("entry reset", 64'h0000_0000_0001_0000, erd); // masked
        foreach (rows[k]) begin
            // each entry unmasked and edge triggered, with its row's vector
            wr_ent(rows[k].idx, ent(rows[k].dest, 1'b0, 1'b0, rows[k].dm,
                rows[k].dlv, rows[k].vec));
            // peripheral raises its irq by a write
            mem_wr(ADDR_PIN_ASSERT, {27'h0, rows[k].idx});
            wait_msg(1);
            exp.dest = rows[k].xdest;
            exp.dmode = rows[k].dm;
            exp.deliv = rows[k].dlv;
            exp.trig = 1'b0;
            exp.vector = rows[k].xvec;
            exp.idx = rows[k].idx;
            chk("sent", {63'h0, rows[k].sent}, {63'h0, ok});
            if (rows[k].sent)
                chk("message", {38'h0, exp}, {38'h0, last_msg});
        end
        mem_wr(ADDR_PIN_ASSERT, 32'hffff_ffe3);
        wait_msg(1);
        chk("upper bits ignored", 64'h3, {59'h0, last_msg.idx});
        mem_wr(ADDR_PIN_ASSERT, 32'h0000_0018);
        mem_wr(32'hfec0_0030, 32'h0000_0003);
        wait_msg(1);
        chk("pin 24 ignored", 64'h0, {63'h0, ok});
        stall = 4'h8;
        mem_wr(ADDR_PIN_ASSERT, 32'h0000_0003);
        rd_ent(5'h03);
        chk("status pending", 64'h1, {63'h0, erd[12]});
        wait_msg(1);
        rd_ent(5'h03);
        chk("status idle", 64'h0, {63'h0, erd[12]});
        stall = 4'h0;
        wr_ent(5'h03, ent(8'hab, 1'b1, 1'b0, 1'b0, DLV_FIXED, 8'h31));
        mem_wr(ADDR_PIN_ASSERT, 32'h0000_0003);
        rd_ent(5'h03);
        chk("masked status", 64'h0, {63'h0, erd[12]});
        wait_msg(1);
        chk("masked silent", 64'h0, {63'h0, ok});
        wr_ent(5'h06, ent(8'h01, 1'b0, 1'b1, 1'b0, DLV_FIXED, 8'h55));
        wr_ent(5'h07, ent(8'h02, 1'b0, 1'b1, 1'b0, DLV_FIXED, 8'h55));
        pins[7:6] = 2'b11;
        wait_msg(2);
        chk("level pair sent", 64'h1, {63'h0, ok});
        rd_ent(5'h06);
        chk("remote set", 64'h1, {63'h0, erd[14]});
        wait_msg(1);
        chk("held by remote", 64'h0, {63'h0, ok});
        mem_wr(ADDR_EOI_CLEAR, 32'hffff_ff56);
        wait_msg(1);
        chk("eoi mismatch", 64'h0, {63'h0, ok});
        mem_wr(ADDR_EOI_CLEAR, 32'hffff_ff55);
        wait_msg(2);
        chk("both reissued", 64'h1, {63'h0, ok});
        pins[7:6] = 2'b00;
        wr_ent(5'h08, ent(8'h03, 1'b0, 1'b1, 1'b0, DLV_NMI, 8'h77));
        pins[8] = 1'b1;
        wait_msg(2);
        chk("nmi resent", 64'h1, {63'h0, ok});
        chk("nmi trig", 64'h0, {63'h0, last_msg.trig});
        rd_ent(5'h08);
        chk("nmi no remote", 64'h0, {63'h0, erd[14]});
        pins[8] = 1'b0;
        // reset while a message stands must drop it and all pending work
        stall = 4'h8;
        mem_wr(ADDR_PIN_ASSERT, 32'h0000_0017);
        for (int c = 0; c < 40 && !valid; c++)
            tick();
        chk("valid before reset", 64'h1, {63'h0, valid});
        rst = 1'b1;
        #1;
        chk("valid in reset", 64'h0, {63'h0, valid});
        chk("msg in reset", 64'h0, {38'h0, msg});
        chk("rdata in reset", 64'h0, erd);
        tick(2);
        rst = 1'b0;
        stall = 4'h0;
        rd_ent(5'h17);
        chk("entry after reset", 64'h0000_0000_0001_0000, erd);
        wait_msg(1);
        chk("silent after reset", 64'h0, {63'h0, ok});
        summarize();
    end
endmodule
`default_nettype wire
